// [scb_regs.svh]
// Purpose: offsets, command codes and reset values of the system control bank
// Assumes: byte-wide register port, byte offsets as printed
// Notes:   definitions only
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH
// register offsets
`define SCB_WDTEST_ADR 8'h09
`define SCB_SWD_ADR    8'h0c
`define SCB_GOC_ADR    8'h0e
`define SCB_ROMID_ADR  8'h2c
`define SCB_RAMID_ADR  8'h2d
`define SCB_CPUID_ADR  8'h2e
`define SCB_REVID_ADR  8'h2f
// watchdog test codes
`define SCB_WT_LOW     8'h51
`define SCB_WT_HIGH    8'h52
`define SCB_WT_BOTH    8'h53
`define SCB_WT_DIS     8'h54
// secondary watchdog disable sequence
`define SCB_SWD_DIS1   8'h5a
`define SCB_SWD_DIS2   8'h52
// id register fields
`define SCB_ID_FETCH   7
`define SCB_ID_BOOT_HI 6
`define SCB_ID_BOOT_LO 5
// reset values and default watchdog limit
`define SCB_GOC_RST    8'h00
`define SCB_SWD_RST    8'hff
`define SCB_WDT_LIMIT  16'hffff
`endif

// [scb_pkg.sv]
// Purpose: shared types of the system control bank
// Assumes: nothing
// Notes:   field layout of the output control register is the struct order
package scb_pkg;
   typedef enum logic [1:0] {
      SCB_WT_NORMAL,
      SCB_WT_LO,
      SCB_WT_HI,
      SCB_WT_PAR
   } scb_wt_mode_t;
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [1:0] stat_sel;
      logic       wdo_low;
      logic       spare;
      logic [1:0] buf_sel;
   } scb_goc_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scb_bus_t;
endpackage : scb_pkg

// [scb_top.sv]
// Purpose: system control register bank with watchdog test/disable,
//          secondary watchdog, output pin control and identity registers
// Assumes: perclk is mclk; osc_32k and boot pins are asynchronous
// Notes:
// How it works
// R1 - test code 51h clocks only watchdog low byte from perclk
// R2 - test code 52h clocks only watchdog high byte from perclk
// R3 - test code 53h clocks both watchdog bytes from perclk
// R4 - 54h disables watchdog only right after 51h, 52h or 53h
// R5 - once disabled, any other test write re-enables the watchdog
// R6 - other test values and reset give normal 32 kHz clocking
// R7 - secondary constant is stored, loaded only when count reaches zero
// R8 - secondary counter counts modulo constant plus one
// R9 - secondary watchdog disabled by write sequence starting 5Ah
// R10 - bits 7:6 pick clock pin: perclk, perclk/2, low, high
// R11 - bits 5:4 status pin: opcode fetch, int ack, low, high
// R12 - bit 3 pulses watchdog pin low 1-2 slow cycles; bit 2 ignored
// R13 - bits 1:0 buffer enable: external io, data memory, low, high
// R14 - id bit 7 reads the fetch-ignore strap
// R15 - id bits 6:5 read current boot mode pins
// R16 - id bits 4:0 fixed rom, ram, cpu, revision codes
// R17 - full byte decoded per write; sequences tracked by flags
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "scb_regs.svh"

module scb_top
   import scb_pkg::*;
#(
   // identity codes: values are arbitrary
   parameter logic [4:0]  ROM_ID    = 5'h03,
   parameter logic [4:0]  RAM_ID    = 5'h05,
   parameter logic [4:0]  CPU_ID    = 5'h06,
   parameter logic [4:0]  REV_ID    = 5'h07,
   parameter logic [15:0] WDT_LIMIT = `SCB_WDT_LIMIT
) (
   // clock and reset
   input  wire logic     mclk,
   input  wire logic     rst_n,
   // register port
   input  wire scb_bus_t bus,
   output logic [7:0]    rdata,
   // pins in
   input  wire logic     osc_32k,
   input  wire logic [1:0] boot_mode_pins,
   input  wire logic     fetch_ignore,
   // cpu cycle status
   input  wire logic     opcode_fetch1,
   input  wire logic     int_ack,
   input  wire logic     io_cycle,
   input  wire logic     data_mem_access,
   input  wire logic     wdt_restart,
   // pins out
   output logic          clk_out,
   output logic          status_n,
   output logic          watchdog_output_n,
   output logic          bus_buffer_enable_n,
   output logic          swd_expire
);

   ////////////////////////////////////////////////////////////////////
   // synchronisers
   logic       osc_meta;
   logic       osc_sync;
   logic       osc_prev;
   logic [1:0] boot_meta;
   logic [1:0] boot_sync;
   logic       fig_meta;
   logic       fig_sync;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_meta  <= 1'b0;
         osc_sync  <= 1'b0;
         osc_prev  <= 1'b0;
         boot_meta <= 2'h0;
         boot_sync <= 2'h0;
         fig_meta  <= 1'b0;
         fig_sync  <= 1'b0;
      end else begin
         osc_meta  <= osc_32k;
         osc_sync  <= osc_meta;
         osc_prev  <= osc_sync;
         boot_meta <= boot_mode_pins;
         boot_sync <= boot_meta;
         fig_meta  <= fetch_ignore;
         fig_sync  <= fig_meta;
      end
   end

   wire tick32 = osc_sync & ~osc_prev;

   ////////////////////////////////////////////////////////////////////
   // write decode
   wire wr_wt  = bus.wr && bus.addr == `SCB_WDTEST_ADR;
   wire wr_swd = bus.wr && bus.addr == `SCB_SWD_ADR;
   wire wr_goc = bus.wr && bus.addr == `SCB_GOC_ADR;
   wire [7:0] wv = bus.wdata;
   wire wv_test = wv == `SCB_WT_LOW || wv == `SCB_WT_HIGH ||
                  wv == `SCB_WT_BOTH;

   ////////////////////////////////////////////////////////////////////
   // watchdog test control
   scb_wt_mode_t wt_mode;
   scb_wt_mode_t next_wt_mode;
   logic         wt_armed;
   logic         wdt_disabled;

   // full byte compared, never a partial field
   always_comb begin
      unique case (wv)
         `SCB_WT_LOW:  next_wt_mode = SCB_WT_LO;   // [R1] [R17]
         `SCB_WT_HIGH: next_wt_mode = SCB_WT_HI;   // [R2]
         `SCB_WT_BOTH: next_wt_mode = SCB_WT_PAR;  // [R3]
         default:      next_wt_mode = SCB_WT_NORMAL; // [R6]
      endcase
   end

   wire next_dis = (wv == `SCB_WT_DIS) && wt_armed; // [R4] [R5]

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wt_mode      <= SCB_WT_NORMAL; // [R6]
         wt_armed     <= 1'b0;
         wdt_disabled <= 1'b0;
      end else if (wr_wt) begin
         wt_mode      <= next_wt_mode;
         wt_armed     <= wv_test;       // [R17]
         wdt_disabled <= next_dis;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // watchdog counter
   logic [15:0] wdt_cnt;
   wire perclk_lo = wt_mode == SCB_WT_LO || wt_mode == SCB_WT_PAR;
   wire perclk_hi = wt_mode == SCB_WT_HI || wt_mode == SCB_WT_PAR;
   wire norm      = wt_mode == SCB_WT_NORMAL;
   // test modes run each byte alone, no carry between them
   wire inc_lo = !wdt_disabled && (perclk_lo || (norm && tick32));
   wire inc_hi = !wdt_disabled && (perclk_hi ||
                 (norm && tick32 && wdt_cnt[7:0] == 8'hff));
   wire wdt_fire = !wdt_disabled && wdt_cnt == WDT_LIMIT;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_cnt <= 16'h0000;
      end else if (wdt_restart || wdt_fire) begin
         wdt_cnt <= 16'h0000;
      end else begin
         if (inc_lo)
            wdt_cnt[7:0] <= wdt_cnt[7:0] + 8'h01;  // [R1] [R3]
         if (inc_hi)
            wdt_cnt[15:8] <= wdt_cnt[15:8] + 8'h01; // [R2] [R3]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // secondary watchdog
   logic [7:0] swd_const;
   logic [7:0] swd_cnt;
   logic       swd_en;
   logic       swd_seq;
   wire swd_dis_hit = swd_seq && wv == `SCB_SWD_DIS2;
   wire swd_zero    = swd_cnt == 8'h00;
   wire swd_step    = swd_en && tick32;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         swd_const <= `SCB_SWD_RST;
         swd_seq   <= 1'b0;
         swd_en    <= 1'b1;
      end else if (wr_swd) begin
         swd_seq <= wv == `SCB_SWD_DIS1;             // [R9] [R17]
         if (swd_dis_hit)
            swd_en <= 1'b0;                          // [R9]
         else if (wv != `SCB_SWD_DIS1)
            swd_const <= wv;                         // [R7]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         swd_cnt    <= `SCB_SWD_RST;
         swd_expire <= 1'b0;
      end else begin
         swd_expire <= swd_step && swd_zero;
         if (swd_step) begin
            if (swd_zero)
               swd_cnt <= swd_const;           // [R7] [R8]
            else
               swd_cnt <= swd_cnt - 8'h01;     // [R8]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output control register and pins
   scb_goc_t goc;
   logic     wdo_force;
   logic     wdo_ticks;
   logic     clk_half;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         goc <= `SCB_GOC_RST;
      end else if (wr_goc) begin
         goc <= wv;
      end
   end

   // pulse ends on the second slow edge, so 1 to 2 slow periods
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wdo_force <= 1'b0;
         wdo_ticks <= 1'b0;
      end else if (wr_goc && wv[3]) begin
         wdo_force <= 1'b1;                    // [R12]
         wdo_ticks <= 1'b0;
      end else if (wdo_force && tick32) begin
         wdo_ticks <= 1'b1;
         if (wdo_ticks)
            wdo_force <= 1'b0;                 // [R12]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_half <= 1'b0;
      end else begin
         clk_half <= ~clk_half;
      end
   end

   // perclk itself can only be passed through, not re-timed
   assign clk_out = goc.clk_sel == 2'b00 ? mclk :      // [R10]
                    goc.clk_sel == 2'b01 ? clk_half :
                    goc.clk_sel[0];

   wire next_status_n = goc.stat_sel == 2'b00 ? ~opcode_fetch1 : // [R11]
                        goc.stat_sel == 2'b01 ? ~int_ack :
                        goc.stat_sel[0];
   wire next_bus_buffer_enable_n_n  = goc.buf_sel == 2'b00 ? ~io_cycle :       // [R13]
                        goc.buf_sel == 2'b01 ? ~data_mem_access :
                        goc.buf_sel[0];
   // goc bit 2 drives no pin; it is only read back
   wire next_wdo_n    = ~(wdo_force || wdt_fire);                // [R12]

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_n            <= 1'b1;
         bus_buffer_enable_n <= 1'b1;
         watchdog_output_n   <= 1'b1;
      end else begin
         status_n            <= next_status_n;
         bus_buffer_enable_n <= next_bus_buffer_enable_n_n;
         watchdog_output_n   <= next_wdo_n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path
   wire [2:0] id_hi = {fig_sync, boot_sync};            // [R14] [R15]
   wire is_id = bus.addr[7:2] == 6'(`SCB_ROMID_ADR >> 2);
   logic [4:0] id_code;
   always_comb begin
      unique case (bus.addr[1:0])
         2'b00:   id_code = ROM_ID;                      // [R16]
         2'b01:   id_code = RAM_ID;
         2'b10:   id_code = CPU_ID;
         default: id_code = REV_ID;
      endcase
   end
   // write-only and unmapped offsets read as zero
   wire [7:0] next_rdata = is_id ? {id_hi, id_code} :
                           bus.addr == `SCB_GOC_ADR ? goc : 8'h00;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_wt_lo;
      @(posedge mclk) disable iff (!rst_n)
      wr_wt && wv == `SCB_WT_LOW |=> wt_mode == SCB_WT_LO;
   endproperty
   a_wt_lo: assert property (p_wt_lo) // [R1]
      else $error("low byte test mode not entered");

   property p_wt_hi;
      @(posedge mclk) disable iff (!rst_n)
      wt_mode == SCB_WT_HI && !wdt_disabled && !wdt_restart && !wdt_fire
      |=> wdt_cnt[15:8] == $past(wdt_cnt[15:8]) + 8'h01 &&
          wdt_cnt[7:0] == $past(wdt_cnt[7:0]);
   endproperty
   a_wt_hi: assert property (p_wt_hi) // [R2]
      else $error("high byte not stepping alone");

   property p_wt_par;
      @(posedge mclk) disable iff (!rst_n)
      wr_wt && wv == `SCB_WT_BOTH |=> perclk_lo && perclk_hi;
   endproperty
   a_wt_par: assert property (p_wt_par) // [R3]
      else $error("parallel test mode not entered");

   property p_dis;
      @(posedge mclk) disable iff (!rst_n)
      wr_wt && wv == `SCB_WT_DIS |=> wdt_disabled == $past(wt_armed);
   endproperty
   a_dis: assert property (p_dis) // [R4]
      else $error("disable sequence misjudged");

   property p_reen;
      @(posedge mclk) disable iff (!rst_n)
      wdt_disabled && wr_wt && wv != `SCB_WT_DIS |=> !wdt_disabled;
   endproperty
   a_reen: assert property (p_reen) // [R5]
      else $error("watchdog not re-enabled");

   property p_norm;
      @(posedge mclk) disable iff (!rst_n)
      wr_wt && !wv_test |=> norm;
   endproperty
   a_norm: assert property (p_norm) // [R6]
      else $error("normal clocking not restored");

   property p_reload;
      @(posedge mclk) disable iff (!rst_n)
      swd_step && swd_zero |=> swd_cnt == $past(swd_const) && swd_expire;
   endproperty
   a_reload: assert property (p_reload) // [R7]
      else $error("secondary reload wrong");

   property p_swd_dec;
      @(posedge mclk) disable iff (!rst_n)
      swd_step && !swd_zero |=> swd_cnt == $past(swd_cnt) - 8'h01;
   endproperty
   a_swd_dec: assert property (p_swd_dec) // [R8]
      else $error("secondary count step wrong");

   property p_swd_off;
      @(posedge mclk) disable iff (!rst_n)
      wr_swd && swd_seq && wv == `SCB_SWD_DIS2 |=> !swd_en [*2];
   endproperty
   a_swd_off: assert property (p_swd_off) // [R9]
      else $error("secondary watchdog not disabled");

   property p_clk_fix;
      @(posedge mclk) disable iff (!rst_n)
      goc.clk_sel[1] |-> clk_out == goc.clk_sel[0];
   endproperty
   a_clk_fix: assert property (p_clk_fix) // [R10]
      else $error("clock pin not held");

   property p_stat;
      @(posedge mclk) disable iff (!rst_n)
      goc.stat_sel == 2'b01 ##1 goc.stat_sel == 2'b01
      |-> status_n == !$past(int_ack);
   endproperty
   a_stat: assert property (p_stat) // [R11]
      else $error("status pin not on int ack");

   property p_wdo;
      @(posedge mclk) disable iff (!rst_n)
      wr_goc && wv[3] |=> ##1 !watchdog_output_n;
   endproperty
   a_wdo: assert property (p_wdo) // [R12]
      else $error("watchdog pin pulse missing");

   property p_buf;
      @(posedge mclk) disable iff (!rst_n)
      goc.buf_sel == 2'b10 |=> !bus_buffer_enable_n;
   endproperty
   a_buf: assert property (p_buf) // [R13]
      else $error("buffer enable not held low");

   property p_id;
      @(posedge mclk) disable iff (!rst_n)
      bus.rd && bus.addr == `SCB_REVID_ADR
      |=> rdata == {$past(fig_sync), $past(boot_sync), REV_ID};
   endproperty
   a_id: assert property (p_id) // [R14] [R15] [R16]
      else $error("identity read wrong");

   c_dis: cover property (@(posedge mclk) disable iff (!rst_n)
      $rose(wdt_disabled));
   c_swd: cover property (@(posedge mclk) disable iff (!rst_n)
      swd_expire);
   c_wdo: cover property (@(posedge mclk) disable iff (!rst_n)
      $fell(wdo_force));

endmodule : scb_top

// [system_control_register_bank_bench.sv]
// Purpose: self-checking bench for the system control register bank
// Assumes: slow oscillator sped up to mclk/8 so watchdog spans stay short
// Notes:   watchdog limit lowered to 20h; ticks come from the bench clock
`timescale 1ns/1ps
`include "scb_regs.svh"

module system_control_register_bank_bench
   import scb_pkg::*;
;
   // arbitrary identity values, handed to the design
   localparam logic [4:0] ROM_C = 5'h03;
   localparam logic [4:0] RAM_C = 5'h05;
   localparam logic [4:0] CPU_C = 5'h06;
   localparam logic [4:0] REV_C = 5'h07;

   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   scb_bus_t   bus = '0;
   logic [7:0] rdata;
   logic       osc_32k = 1'b0;
   logic [1:0] boot_mode_pins = 2'b00;
   logic       fetch_ignore = 1'b0;
   logic       opcode_fetch1 = 1'b0, int_ack = 1'b0;
   logic       io_cycle = 1'b0, data_mem_access = 1'b0;
   logic       wdt_restart = 1'b0;
   logic       clk_out, status_n, watchdog_output_n;
   logic       bus_buffer_enable_n, swd_expire;
   logic [2:0] osc_div = 3'h0;
   int         bad_count = 0, checks = 0;
   int         cyc = 0, wdo_lows = 0, exp_cnt = 0, exp_last = 0;
   int         t0, s, i;
   logic [3:0] pr;

   scb_top #(.ROM_ID(ROM_C), .RAM_ID(RAM_C), .CPU_ID(CPU_C),
      .REV_ID(REV_C), .WDT_LIMIT(16'h0020)) uut (
      .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .osc_32k(osc_32k), .boot_mode_pins(boot_mode_pins),
      .fetch_ignore(fetch_ignore), .opcode_fetch1(opcode_fetch1),
      .int_ack(int_ack), .io_cycle(io_cycle),
      .data_mem_access(data_mem_access), .wdt_restart(wdt_restart),
      .clk_out(clk_out), .status_n(status_n),
      .watchdog_output_n(watchdog_output_n),
      .bus_buffer_enable_n(bus_buffer_enable_n), .swd_expire(swd_expire));

   always #50 mclk = ~mclk;

   // oscillator made in step with mclk so tick spacing is exact
   always @(posedge mclk) begin
      cyc     <= cyc + 1;
      osc_div <= osc_div + 3'h1;
      osc_32k <= osc_div[2];
      if (rst_n && watchdog_output_n === 1'b0)
         wdo_lows <= wdo_lows + 1;
      if (rst_n && swd_expire === 1'b1) begin
         exp_cnt  <= exp_cnt + 1;
         exp_last <= cyc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus.wr    <= 1'b1;
      bus.addr  <= a;
      bus.wdata <= d;
      @(posedge mclk);
      bus.wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      bus.rd   <= 1'b1;
      bus.addr <= a;
      @(posedge mclk);
      bus.rd   <= 1'b0;
      // read data taken at the edge that closes its one cycle
      @(posedge mclk);
      chk(16'(rdata), 16'(exp));
   endtask : rd

   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask : waitc

   // restart, then let the restart edge settle before opening a window
   task automatic win(input int n, input logic any);
      @(posedge mclk);
      wdt_restart <= 1'b1;
      @(posedge mclk);
      wdt_restart <= 1'b0;
      waitc(3);
      s = wdo_lows;
      waitc(n);
      chk(16'(wdo_lows != s), 16'(any));
   endtask : win

   task automatic wait_exp();
      s = exp_cnt;
      for (int k = 0; k < 3000 && exp_cnt == s; k++)
         waitc(1);
      chk(16'(exp_cnt != s), 16'h0001);
   endtask : wait_exp

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge mclk);
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`SCB_GOC_ADR, `SCB_GOC_RST);
      win(400, 1'b1);
      wr(`SCB_WDTEST_ADR, `SCB_WT_LOW);
      win(100, 1'b1);
      wr(`SCB_WDTEST_ADR, `SCB_WT_HIGH);
      win(300, 1'b0);
      wr(`SCB_WDTEST_ADR, `SCB_WT_BOTH);
      win(300, 1'b0);
      for (i = 0; i < 3; i++) begin
         wr(`SCB_WDTEST_ADR, `SCB_WT_LOW + 8'(i));
         wr(`SCB_WDTEST_ADR, `SCB_WT_DIS);
         win(400, 1'b0);
         wr(`SCB_WDTEST_ADR, 8'h00);
         win(400, 1'b1);
      end
      // lone disable code after a plain write leaves it running
      wr(`SCB_WDTEST_ADR, `SCB_WT_DIS);
      win(400, 1'b1);
      wr(`SCB_WDTEST_ADR, `SCB_WT_BOTH);
      wr(`SCB_WDTEST_ADR, `SCB_WT_DIS);
      s = wdo_lows;
      wr(`SCB_GOC_ADR, 8'h08);
      waitc(40);
      chk(16'(wdo_lows - s >= 7 && wdo_lows - s <= 18), 16'h0001);
      chk(16'(watchdog_output_n), 16'h0001);
      wr(`SCB_GOC_ADR, 8'h04);
      rd(`SCB_GOC_ADR, 8'h04);
      for (i = 0; i < 4; i++) begin
         wr(`SCB_GOC_ADR, {2'b00, 2'(i), 2'b00, 2'(i)});
         rd(`SCB_GOC_ADR, {2'b00, 2'(i), 2'b00, 2'(i)});
         opcode_fetch1 <= 1'b1;
         io_cycle      <= 1'b1;
         waitc(2);
         chk(16'(status_n), 16'(i == 1 || i == 3));
         chk(16'(bus_buffer_enable_n), 16'(i == 1 || i == 3));
         opcode_fetch1   <= 1'b0;
         io_cycle        <= 1'b0;
         int_ack         <= 1'b1;
         data_mem_access <= 1'b1;
         waitc(2);
         chk(16'(status_n), 16'(i == 0 || i == 3));
         chk(16'(bus_buffer_enable_n), 16'(i == 0 || i == 3));
         int_ack         <= 1'b0;
         data_mem_access <= 1'b0;
      end
      for (i = 0; i < 4; i++) begin
         wr(`SCB_GOC_ADR, {2'(i), 6'h00});
         @(posedge mclk);
         #1 pr[3] = clk_out;
         @(negedge mclk);
         #1 pr[2] = clk_out;
         @(posedge mclk);
         #1 pr[1] = clk_out;
         @(negedge mclk);
         #1 pr[0] = clk_out;
         if (i == 1)
            chk(16'({pr[3] === pr[2], pr[1] !== pr[3]}), 16'h0003);
         else
            chk(16'(pr), (i == 0) ? 16'h000a : (i == 2) ? 16'h0 : 16'h000f);
      end
      @(posedge mclk);
      fetch_ignore   <= 1'b1;
      boot_mode_pins <= 2'b10;
      waitc(4);
      rd(`SCB_ROMID_ADR, {3'b110, ROM_C});
      rd(`SCB_RAMID_ADR, {3'b110, RAM_C});
      rd(`SCB_CPUID_ADR, {3'b110, CPU_C});
      fetch_ignore   <= 1'b0;
      boot_mode_pins <= 2'b01;
      waitc(4);
      wr(`SCB_REVID_ADR, 8'hff);
      rd(`SCB_REVID_ADR, {3'b001, REV_C});
      rd(8'h30, 8'h00);
      rd(`SCB_WDTEST_ADR, 8'h00);
      wait_exp();
      wr(`SCB_SWD_ADR, 8'h03);
      t0 = exp_last;
      wait_exp();
      chk(16'(exp_last - t0), 16'd2048);
      t0 = exp_last;
      wait_exp();
      chk(16'(exp_last - t0), 16'd32);
      wr(`SCB_SWD_ADR, `SCB_SWD_DIS1);
      wr(`SCB_SWD_ADR, `SCB_SWD_DIS2);
      // a pulse launched at the disabling edge itself is still legal
      waitc(2);
      s = exp_cnt;
      waitc(100);
      chk(16'(exp_cnt != s), 16'h0000);
      complete_run();
   end
endmodule : system_control_register_bank_bench
